// file: src/spr_pkg.sv
/*
 Shared constants of the SPI master read-command sequencer: register offsets,
 field positions, reset values, serial clock timing and sequencer states.
 Assumes a 100 MHz system clock and a 16-bit register port.
*/
// Notes on behaviour
// R1: Pin-count select 0 gives separate data lines, 1 gives one shared data line.
// R2: Command transmit count bits [5:2] hold transmitted bytes minus one, 1 to 16 bytes.
// R3: Software counts latency padding bytes, usually zeros, inside the command transmit count.
// R4: Without overlap, read data are accepted only after all command bytes are sent.
// R5: With overlap, reception runs during transmission; transfer count is total bytes received.
// R6: With overlap, software adds the slave's status bytes into the transfer count.
// R7: Read command enable sends command then receives data within one chip-select frame.
// R8: Read command controls act only in master operation and are ignored otherwise.
// R9: Three-pin: master drives shared line while sending, slave drives it after the wait.
// R10: Three-pin use needs overlap cleared, read command mode and flow-control mode 1; the code inserts the wait in three-pin mode in any flow mode.
// R11: After the last read byte the master raises chip select and flags completion.
package spr_pkg;
  localparam logic [4:0] OFS_RCC = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_WAIT = 5'h08;
  localparam logic [4:0] OFS_FLOW = 5'h0c;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_TXDATA = 5'h18;
  localparam logic [4:0] OFS_RXDATA = 5'h1c;

  localparam int BIT_RDCMD_EN = 0;
  localparam int BIT_OVERLAP = 1;
  localparam int POS_TXCOUNT = 2;
  localparam int BIT_PINSEL = 8;
  localparam logic [15:0] RCC_MASK = 16'h013f;
  localparam logic [15:0] RCC_RESET = 16'h0000;
  localparam logic [13:0] COUNT_RESET = 14'h0000;
  localparam logic [15:0] WAIT_RESET = 16'h0000;
  localparam logic [1:0] FLOW_RESET = 2'h0;
  localparam logic [1:0] FLOW_WAIT_MODE = 2'h1;

  localparam int BIT_MASTER = 0;
  localparam int BIT_START = 1;
  localparam int BIT_DONE = 0;
  localparam int BIT_BUSY = 1;
  localparam int POS_TXLVL = 2;
  localparam int POS_RXLVL = 7;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 40;
  localparam logic [2:0] SCK_HALF_CYC = 3'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_TURN = 2'b10,
    ST_FIN = 2'b11
  } spr_state_t;
endpackage

// file: src/spr_sync.sv
/*
 Two-stage synchroniser for inputs from outside the clock domain.
 Assumes inputs are levels that stay put for several clock cycles.
*/
`timescale 1ns/1ps
module spr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } spr_sync_t;

  spr_sync_t s;
  spr_sync_t next_s;

  always_comb begin
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.s2;
endmodule

// file: src/spr_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and a fill level.
 Assumes DEPTH is a power of two; head data are shown while out_valid is high.
*/
`timescale 1ns/1ps
module spr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spr_fifo_t;

  spr_fifo_t s;
  spr_fifo_t next_s;
  logic full;
  logic empty;

  assign level_out = s.wp - s.rp;
  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = s.wp == s.rp;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid_in && !full) begin
      next_s.mem[s.wp[AW-1:0]] = in_data_in;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_ready_in && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// file: src/spr_read_cmd.sv
/*
 SPI master read-command sequencer with its register port, a command FIFO and
 a receive FIFO. Serial clock is mode 0 (idle low, sample on rising edge),
 derived from mclk_in. Assumes a master that strobes one register access per
 cycle; the slave pins are asynchronous and pass a two-stage synchroniser.
*/
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module spr_read_cmd (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic sclk_out,
  output logic chip_select_line_n_out,
  output logic master_out_line_out,
  output logic master_out_line_oe_out,
  input wire logic master_out_line_in,
  input wire logic miso_in,
  output logic busy_out
);
  localparam int LW = $clog2(spr_pkg::FIFO_DEPTH) + 1;

  typedef struct packed {
    // Register file
    logic [15:0] rcc;
    logic [13:0] count;
    logic [15:0] wait_tmr;
    logic [1:0] flow;
    logic master;
    logic done;

    // Sequencer and pin state
    spr_pkg::spr_state_t state;
    logic loaded;
    logic sclk;
    logic cs_n;
    logic busy;
    logic mosi;
    logic mosi_oe;

    // Byte engine
    logic [2:0] div;
    logic [2:0] bitn;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [13:0] txleft;
    logic [13:0] rxleft;
    logic ovl;
    logic rxact;
    logic [15:0] wcnt;
    logic [15:0] rdata;
  } spr_regs_t;

  spr_regs_t s;
  spr_regs_t next_s;

  // Synchronised pins and FIFO handshakes
  logic [1:0] pins;
  logic din;
  logic three_pin;
  logic cmd_en;
  logic tx_push;
  logic tx_ready;
  logic tx_valid;
  logic tx_pop;
  logic [7:0] tx_head;
  logic [LW-1:0] tx_level;
  logic rx_push;
  logic rx_ready;
  logic rx_valid;
  logic rx_pop;
  logic [7:0] rx_head;
  logic [LW-1:0] rx_level;
  logic [7:0] rx_byte;

  // Both data inputs arrive from off-chip
  spr_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({master_out_line_in, miso_in}),
    .q_out(pins)
  );

  // Control fields
  assign three_pin = s.rcc[spr_pkg::BIT_PINSEL];
  assign cmd_en = s.rcc[spr_pkg::BIT_RDCMD_EN];
  // Shared line in three-pin mode, dedicated input otherwise
  assign din = three_pin ? pins[1] : pins[0]; // R1
  assign tx_push = wr_in && (addr_in == spr_pkg::OFS_TXDATA);
  assign rx_pop = rd_in && (addr_in == spr_pkg::OFS_RXDATA);
  assign rx_byte = {s.rxsh[6:0], din};

  // Command bytes wait here until the engine loads them
  spr_fifo #(
    .WIDTH(spr_pkg::FIFO_WIDTH),
    .DEPTH(spr_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(tx_push),
    .in_ready_out(tx_ready),
    .in_data_in(wdata_in[7:0]),
    .out_valid_out(tx_valid),
    .out_ready_in(tx_pop),
    .out_data_out(tx_head),
    .level_out(tx_level)
  );

  // Received bytes wait here until software pops them
  spr_fifo #(
    .WIDTH(spr_pkg::FIFO_WIDTH),
    .DEPTH(spr_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(rx_push),
    .in_ready_out(rx_ready),
    .in_data_in(s.rxsh),
    .out_valid_out(rx_valid),
    .out_ready_in(rx_pop),
    .out_data_out(rx_head),
    .level_out(rx_level)
  );

  always_comb begin
    logic need_tx;
    logic want_rx;
    need_tx = 1'b0;
    want_rx = 1'b0;
    next_s = s;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    next_s.rdata = 16'h0000;

    // Register reads are answered one cycle later
    if (rd_in) begin
      unique case (addr_in)
        spr_pkg::OFS_RCC: next_s.rdata = s.rcc;
        spr_pkg::OFS_COUNT: next_s.rdata = {2'h0, s.count};
        spr_pkg::OFS_WAIT: next_s.rdata = s.wait_tmr;
        spr_pkg::OFS_FLOW: next_s.rdata = {14'h0000, s.flow};
        spr_pkg::OFS_CTRL: next_s.rdata = {15'h0000, s.master};
        spr_pkg::OFS_STAT: begin
          next_s.rdata[spr_pkg::BIT_DONE] = s.done;
          next_s.rdata[spr_pkg::BIT_BUSY] = s.state != spr_pkg::ST_IDLE;
          next_s.rdata[spr_pkg::POS_TXLVL +: LW] = tx_level;
          next_s.rdata[spr_pkg::POS_RXLVL +: LW] = rx_level;
        end
        spr_pkg::OFS_RXDATA: next_s.rdata = {8'h00, rx_valid ? rx_head : 8'h00};
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        spr_pkg::OFS_RCC: next_s.rcc = wdata_in & spr_pkg::RCC_MASK;
        spr_pkg::OFS_COUNT: next_s.count = wdata_in[13:0];
        spr_pkg::OFS_WAIT: next_s.wait_tmr = wdata_in;
        spr_pkg::OFS_FLOW: next_s.flow = wdata_in[1:0];
        spr_pkg::OFS_CTRL: next_s.master = wdata_in[spr_pkg::BIT_MASTER];
        spr_pkg::OFS_STAT: begin
          if (wdata_in[spr_pkg::BIT_DONE]) begin
            next_s.done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Frame sequencer
    unique case (s.state)
      spr_pkg::ST_IDLE: begin
        next_s.cs_n = 1'b1;
        next_s.sclk = 1'b0;
        next_s.mosi_oe = !three_pin; // R1
        // Start only in master operation; settings are inert otherwise
        if (wr_in && addr_in == spr_pkg::OFS_CTRL && wdata_in[spr_pkg::BIT_START] && s.master) begin // R8
          next_s.state = spr_pkg::ST_XFER;
          next_s.cs_n = 1'b0;
          next_s.loaded = 1'b0;
          next_s.rxleft = s.count; // R5
          if (cmd_en) begin // R7
            next_s.txleft = 14'(s.rcc[spr_pkg::POS_TXCOUNT +: 4]) + 14'h0001; // R2
            next_s.ovl = s.rcc[spr_pkg::BIT_OVERLAP];
          end else begin
            next_s.txleft = s.count;
            next_s.ovl = 1'b1;
          end
        end
      end

      spr_pkg::ST_XFER: begin
        // Load the next byte when both FIFOs allow it
        if (!s.loaded) begin
          need_tx = s.txleft != 14'h0000;
          // Receive during sending only with overlap
          want_rx = (s.rxleft != 14'h0000) && (s.ovl || !need_tx); // R4 R5
          if (!need_tx && s.rxleft == 14'h0000) begin
            next_s.state = spr_pkg::ST_FIN; // R11
          end else if ((!need_tx || tx_valid) && (!want_rx || rx_ready)) begin
            tx_pop = need_tx;
            next_s.loaded = 1'b1;
            next_s.div = 3'h0;
            next_s.bitn = 3'h0;
            next_s.rxact = want_rx;
            next_s.txsh = need_tx ? tx_head : 8'h00;
            next_s.mosi = need_tx ? tx_head[7] : 1'b0;
            // Three-pin: drive the shared line only while sending
            next_s.mosi_oe = !three_pin || need_tx; // R9
          end
        end else begin
          // Serial clock divider and bit shift
          next_s.div = s.div + 3'h1;
          if (s.div == spr_pkg::SCK_HALF_CYC - 3'h1) begin
            next_s.div = 3'h0;
            if (!s.sclk) begin
              // Rising edge samples the data line
              next_s.sclk = 1'b1;
              next_s.rxsh = rx_byte;
            end else begin
              // Falling edge shifts out and may end the byte
              next_s.sclk = 1'b0;
              next_s.txsh = {s.txsh[6:0], 1'b0};
              next_s.mosi = s.txsh[6];
              next_s.bitn = s.bitn + 3'h1;
              if (s.bitn == 3'h7) begin
                // Byte complete: push the assembled byte if receiving and count down
                next_s.loaded = 1'b0;
                rx_push = s.rxact;
                if (s.txleft != 14'h0000) begin
                  next_s.txleft = s.txleft - 14'h0001;
                end
                if (s.rxact) begin
                  next_s.rxleft = s.rxleft - 14'h0001;
                end
                // Turnaround gap between last command byte and first read byte
                if (!s.ovl && s.txleft == 14'h0001 && s.rxleft != 14'h0000 &&
                    (three_pin || s.flow == spr_pkg::FLOW_WAIT_MODE)) begin // R9 R10
                  next_s.state = spr_pkg::ST_TURN;
                  next_s.wcnt = 16'h0000;
                  next_s.mosi_oe = !three_pin; // R9
                end
              end
            end
          end
        end
      end

      // Idle gap with the serial clock held low
      spr_pkg::ST_TURN: begin
        next_s.wcnt = s.wcnt + 16'h0001;
        if (s.wcnt + 16'h0001 >= s.wait_tmr) begin // R9
          next_s.state = spr_pkg::ST_XFER;
        end
      end

      // Close the frame
      spr_pkg::ST_FIN: begin
        next_s.cs_n = 1'b1; // R11
        next_s.done = 1'b1; // R11
        next_s.state = spr_pkg::ST_IDLE;
      end
    endcase

    // Busy mirrors chip select from a flop of its own
    next_s.busy = !next_s.cs_n;
  end

  // Synchronous reset to the defaults
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.rcc <= spr_pkg::RCC_RESET;
      s.count <= spr_pkg::COUNT_RESET;
      s.wait_tmr <= spr_pkg::WAIT_RESET;
      s.flow <= spr_pkg::FLOW_RESET;
      s.state <= spr_pkg::ST_IDLE;
      s.cs_n <= 1'b1;
      s.mosi_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end


  // Every output port comes from a flop
  assign rdata_out = s.rdata;
  assign sclk_out = s.sclk;
  assign chip_select_line_n_out = s.cs_n;
  assign master_out_line_out = s.mosi;
  assign master_out_line_oe_out = s.mosi_oe;
  assign busy_out = s.busy;
endmodule

// file: verif/spr_read_cmd_monitor.sv
/*
 Concurrent checks on the read-command sequencer's ports.
 Assumes one clock domain and the register offsets of spr_pkg.
*/
`timescale 1ns/1ps
module spr_read_cmd_monitor (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic sclk_out,
  input wire logic chip_select_line_n_out,
  input wire logic master_out_line_oe_out,
  input wire logic busy_out
);
  logic master_q;
  logic pin_q;
  logic cmd_q;
  logic sclk_q;
  logic [7:0] edges;
  wire logic ctl_wr = wr_in && addr_in == spr_pkg::OFS_CTRL;
  wire logic rc_wr = wr_in && addr_in == spr_pkg::OFS_RCC;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Shadows of control bits and count of serial clock rises per frame
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      master_q <= 1'b0;
      pin_q <= 1'b0;
      cmd_q <= 1'b0;
      sclk_q <= 1'b0;
      edges <= 8'h00;
    end else begin
      sclk_q <= sclk_out;
      if (ctl_wr) begin
        master_q <= wdata_in[0];
      end
      if (rc_wr) begin
        pin_q <= wdata_in[8];
        cmd_q <= wdata_in[0];
      end
      if (chip_select_line_n_out) begin
        edges <= 8'h00;
      end else if (sclk_out && !sclk_q) begin
        edges <= edges + 8'h01;
      end
    end
  end
  sequence go_s;
    ctl_wr && wdata_in[1] && chip_select_line_n_out;
  endsequence
  sequence pulse_s;
    sclk_out [*4] ##1 !sclk_out;
  endsequence
  busy_track_a: assert property (busy_out == !chip_select_line_n_out)
    else $error("busy differs from chip select");
  idle_sclk_a: assert property (chip_select_line_n_out |-> !sclk_out)
    else $error("serial clock outside frame");
  half_period_a: assert property ($rose(sclk_out) |-> pulse_s)
    else $error("serial clock high phase wrong");
  start_ok_a: assert property (go_s ##0 master_q |=> !chip_select_line_n_out)
    else $error("start did not open frame");
  slave_off_a: assert property (go_s ##0 !master_q |=> chip_select_line_n_out [*2])
    else $error("frame opened in slave operation");
  whole_bytes_a: assert property ($rose(chip_select_line_n_out) |-> edges[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  frame_min_a: assert property ($fell(chip_select_line_n_out) && cmd_q |-> !chip_select_line_n_out [*8])
    else $error("command frame too short");
  four_pin_a: assert property (!pin_q && !chip_select_line_n_out && sclk_out |-> master_out_line_oe_out)
    else $error("data line released in four-pin mode");
  turn_over_a: assert property ($fell(master_out_line_oe_out) |-> pin_q && (chip_select_line_n_out || !sclk_out))
    else $error("data line released at wrong time");
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  ctl_bits_a: assert property (rd_in && addr_in == spr_pkg::OFS_RCC |=> (rdata_out & ~spr_pkg::RCC_MASK) == 16'h0000)
    else $error("reserved control bits set");
endmodule
bind spr_read_cmd spr_read_cmd_monitor u_mon (.mclk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .sclk_out, .chip_select_line_n_out, .master_out_line_oe_out, .busy_out);

// file: verif/spr_slave_model.sv
/*
 Behavioural serial slave: returns byte k of a frame as k xor 0x5a, mode 0.
 Assumes the bench resolves the shared data line from the master's enable.
*/
`timescale 1ns/1ps
module spr_slave_model (
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic three_pin_in,
  output logic miso_out,
  output logic line_out,
  output int nbytes_out,
  output logic [7:0] first_out
);
  logic [7:0] sr = 8'h00;
  logic [7:0] rx;
  int bits;
  // Outside a frame line_out, and miso_out in four-pin mode, show the inverse of the last bit
  wire logic d = cs_n_in ? ~sr[7] : sr[7];
  assign line_out = d;
  assign miso_out = three_pin_in ? ~d : d;
  always @(negedge cs_n_in) begin
    sr = 8'h5a;
    bits = 0;
    nbytes_out = 0;
  end
  always @(posedge sclk_in) if (!cs_n_in) begin
    rx = {rx[6:0], mosi_in};
    bits++;
    if (bits % 8 == 0) begin
      if (nbytes_out == 0) first_out = rx;
      nbytes_out++;
    end
  end
  always @(negedge sclk_in) if (!cs_n_in) begin
    if (bits % 8 == 0) sr = 8'(bits / 8) ^ 8'h5a;
    else sr = sr << 1;
  end
endmodule

// file: verif/spr_read_cmd_test.sv
/*
 Self-checking bench for the read-command sequencer over its register port.
 Assumes the slave model's byte pattern and a 100 MHz clock.
*/
`timescale 1ns/1ps
module spr_read_cmd_test;
  logic mclk_in, sys_rst_in, wr_in, rd_in, pin3;
  logic [4:0] addr_in;
  logic [15:0] wdata_in, rdata_out, rv;
  logic sclk_out, cs_n, mol, oe, miso, busy_out, sl_line;
  logic [7:0] sfirst;
  int nb, checks = 0, miscompares = 0;
  wire logic line_w = oe ? mol : sl_line;
  spr_read_cmd u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sclk_out(sclk_out), .chip_select_line_n_out(cs_n),
    .master_out_line_out(mol), .master_out_line_oe_out(oe), .master_out_line_in(line_w), .miso_in(miso),
    .busy_out(busy_out));
  spr_slave_model u_slave (.sclk_in(sclk_out), .cs_n_in(cs_n), .mosi_in(line_w), .three_pin_in(pin3),
    .miso_out(miso), .line_out(sl_line), .nbytes_out(nb), .first_out(sfirst));
  always #5 mclk_in = ~mclk_in;
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // One frame: program, push, start, wait, then compare the slave and rx data
  task automatic run(input bit cmd, input bit ovl, input bit pin, input int ntx, input int cnt);
    int tot, first, n;
    logic [15:0] v;
    n = cmd ? ntx : cnt;
    tot = !cmd ? cnt : ovl ? (ntx > cnt ? ntx : cnt) : ntx + cnt;
    first = (cmd && !ovl) ? ntx : 0;
    pin3 = pin;
    wr(spr_pkg::OFS_RCC, {7'h00, pin, 2'h0, 4'(ntx - 1), ovl, cmd});
    wr(spr_pkg::OFS_COUNT, 16'(cnt));
    for (int i = 0; i < n + (n == 16); i++) wr(spr_pkg::OFS_TXDATA, 16'h00c0 + 16'(i));
    rd(spr_pkg::OFS_STAT, v);
    check({11'h000, v[6:2]}, 16'(n));
    wr(spr_pkg::OFS_CTRL, 16'h0003);
    repeat (2) @(posedge mclk_in);
    for (int i = 0; i < 4000 && busy_out !== 1'b0; i++) @(posedge mclk_in);
    check(16'(nb), 16'(tot));
    check({8'h00, sfirst}, 16'h00c0);
    rd(spr_pkg::OFS_STAT, v);
    check({15'h0000, v[0]}, 16'h0001);
    wr(spr_pkg::OFS_STAT, 16'h0001);
    for (int i = 0; i <= cnt; i++) begin
      rd(spr_pkg::OFS_RXDATA, v);
      check(v, i < cnt ? {8'h00, 8'(first + i) ^ 8'h5a} : 16'h0000);
    end
    $display("%0t test frame tx %0d rx %0d done", $time, ntx, cnt);
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    addr_in = 5'h00;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    pin3 = 1'b0;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(5'(4 * i), rv);
      check(rv, 16'h0000);
    end
    rd(5'h02, rv);
    check(rv, 16'h0000);
    wr(spr_pkg::OFS_RCC, 16'hffff);
    rd(spr_pkg::OFS_RCC, rv);
    check(rv, 16'h013f);
    $display("%0t test registers done", $time);
    wr(spr_pkg::OFS_CTRL, 16'h0002);
    repeat (4) @(posedge mclk_in);
    check({15'h0000, busy_out}, 16'h0000);
    wr(spr_pkg::OFS_CTRL, 16'h0001);
    run(1'b1, 1'b0, 1'b0, 1, 2);
    run(1'b1, 1'b1, 1'b0, 3, 2);
    run(1'b1, 1'b1, 1'b0, 1, 3);
    run(1'b1, 1'b0, 1'b0, 16, 1);
    run(1'b0, 1'b0, 1'b0, 1, 3);
    wr(spr_pkg::OFS_FLOW, 16'h0001);
    wr(spr_pkg::OFS_WAIT, 16'h0005);
    run(1'b1, 1'b0, 1'b1, 1, 2);
    summarize();
  end
endmodule
